// ==== shared/crc_cfg.svh ====
`ifndef CRC16_PKT_CFG_SVH
`define CRC16_PKT_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define CRC_OFS_CONTROL     4'h0
`define CRC_OFS_INPUT_WORD  4'h4
`define CRC_OFS_RESULT      4'h8

// ==========================================================
// control register fields
`define CRC_MODE_BIT        16
`define CRC_LEN_MSB         8
`define CRC_LEN_LSB         0

// ==========================================================
// reset values and arithmetic
`define CRC_CONTROL_RESET   32'h0000_0000
`define CRC_INPUT_RESET     32'h0000_0000
`define CRC_SEED            16'hffff
`define CRC_POLY            16'h1021
`define CRC_BYTES_PER_WORD  3'h4
`define CRC_LAST_LANE       2'h3

`endif

// ==== shared/crc16_pkg.sv ====
package crc16_pkg;

  // byte order inside an input word
  typedef enum logic {
    MSB_FIRST,
    LSB_FIRST
  } byte_order_type;

  // word engine state
  typedef enum logic {
    ENGINE_IDLE,
    ENGINE_SHIFT
  } engine_state_type;

endpackage

// ==== core/byte_lane_picker.sv ====
`timescale 1ns/1ns
`default_nettype none

`include "crc_cfg.svh"

module byte_lane_picker
  import crc16_pkg::*;
(
  // word and position
  input  wire logic [31:0]        word,
  input  wire logic [1:0]         step,
  input  wire crc16_pkg::byte_order_type order,
  // selected byte
  output logic      [7:0]         lane_byte
);

  logic [1:0] lane;

  always_comb begin
    if (order == LSB_FIRST) begin
      lane = step;
    end else begin
      lane = `CRC_LAST_LANE - step;
    end
    lane_byte = word[{lane, 3'h0} +: 8];
  end

endmodule

`default_nettype wire

// ==== core/crc16_byte_step.sv ====
`timescale 1ns/1ns
`default_nettype none

`include "crc_cfg.svh"

module crc16_byte_step (
  // current remainder and new byte
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // remainder after the byte
  output logic      [15:0] crc_out
);

  // msb first, no reflection, no final inversion
  function automatic logic [15:0] step_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r  = c;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  always_comb begin
    crc_out = step_byte(crc_in, data_in);
  end

endmodule

`default_nettype wire

// ==== core/crc16_packet_generator.sv ====
// Notes on behaviour
// - result is a 16-bit CRC with polynomial x^16+x^12+x^5+1.
// - data arrives as whole 32-bit word writes, four bytes each.
// - control bit 16 picks byte order: 0 high byte first, 1 low byte first.
// - any control write clears the count of processed bytes.
// - writing the length presets the running CRC to 0xffff.
// - any control write discards old state and starts a new calculation.
// - length field bits 8:0 holds bytes minus one, 511 means 512 bytes.
// - CRC stops updating after length plus one bytes are processed.
// - result shows the updated CRC four cycles after each word write.
// - data followed by its own CRC, high byte first, gives result zero.
// - result register is read only, low 16 bits, 0x0000ffff after reset.
// - bytes beyond the programmed length are ignored.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none

`include "crc_cfg.svh"

module crc16_packet_generator
  import crc16_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rdata_q,
  // status
  output logic                   shift_busy_q
);

  import crc16_pkg::*;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  logic wr_ctl;
  logic wr_dat;
  logic rd_ctl;
  logic rd_dat;
  logic rd_res;

  always_comb begin
    wr_ctl = 1'b0;
    wr_dat = 1'b0;
    rd_ctl = 1'b0;
    rd_dat = 1'b0;
    rd_res = 1'b0;
    if (hit(addr, `CRC_OFS_CONTROL)) begin
      wr_ctl = wr_en;
      rd_ctl = rd_en;
    end else if (hit(addr, `CRC_OFS_INPUT_WORD)) begin
      wr_dat = wr_en;
      rd_dat = rd_en;
    end else if (hit(addr, `CRC_OFS_RESULT)) begin
      rd_res = rd_en;
    end
  end

  // ==========================================================
  // control register
  byte_order_type order_q;
  logic [8:0]     len_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      order_q <= MSB_FIRST;
      len_q   <= 9'(`CRC_CONTROL_RESET);
    end else if (wr_ctl) begin
      order_q <= byte_order_type'(wdata[`CRC_MODE_BIT]);
      len_q   <= wdata[`CRC_LEN_MSB:`CRC_LEN_LSB];
    end
  end

  // ==========================================================
  // input word register
  logic [31:0] word_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_q <= `CRC_INPUT_RESET;
    end else if (wr_dat) begin
      word_q <= wdata;
    end
  end

  // ==========================================================
  // byte engine: one byte per cycle, four cycles per word
  engine_state_type state_q;
  logic [1:0]       step_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ENGINE_IDLE;
      step_q  <= 2'h0;
    end else if (wr_ctl) begin
      state_q <= ENGINE_IDLE;
      step_q  <= 2'h0;
    end else if (wr_dat) begin
      // a word written too early simply restarts the split
      state_q <= ENGINE_SHIFT;
      step_q  <= 2'h0;
    end else begin
      case (state_q)
        ENGINE_IDLE: begin
          step_q <= 2'h0;
        end
        ENGINE_SHIFT: begin
          if (step_q == `CRC_LAST_LANE) begin
            state_q <= ENGINE_IDLE;
            step_q  <= 2'h0;
          end else begin
            step_q <= step_q + 2'h1;
          end
        end
        default: begin
          state_q <= ENGINE_IDLE;
        end
      endcase
    end
  end

  logic shifting;
  assign shifting = (state_q == ENGINE_SHIFT);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_busy_q <= 1'b0;
    end else if (wr_ctl) begin
      shift_busy_q <= 1'b0;
    end else if (wr_dat) begin
      shift_busy_q <= 1'b1;
    end else if (shifting && step_q == `CRC_LAST_LANE) begin
      shift_busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // byte selection and remainder update
  logic [7:0]  cur_byte;
  logic [15:0] next_crc;
  logic [15:0] crc_q;
  logic [9:0]  count_q;
  logic        in_packet;

  byte_lane_picker u_picker (
    .word      (word_q),
    .step      (step_q),
    .order     (order_q),
    .lane_byte (cur_byte)
  );

  crc16_byte_step u_step (
    .crc_in  (crc_q),
    .data_in (cur_byte),
    .crc_out (next_crc)
  );

  // count is 10 bits so 512 processed bytes still compare above 511
  assign in_packet = (count_q <= {1'b0, len_q});

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= 10'h000;
    end else if (wr_ctl) begin
      count_q <= 10'h000;
    end else if (shifting && in_packet) begin
      count_q <= count_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_q <= `CRC_SEED;
    end else if (wr_ctl) begin
      crc_q <= `CRC_SEED;
    end else if (shifting && in_packet) begin
      crc_q <= next_crc;
    end
  end

  // ==========================================================
  // read data, valid only in the cycle after the strobe
  // read only result
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_ctl) begin
      rdata_q <= {15'h0, order_q, 7'h00, len_q};
    end else if (rd_dat) begin
      rdata_q <= word_q;
    end else if (rd_res) begin
      rdata_q <= {16'h0000, crc_q};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // assertions

  AST_SEED_AFTER_CONTROL: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctl |=> crc_q == `CRC_SEED)
    else $error("crc not preset after control write");

  AST_COUNT_CLEARED: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctl |=> count_q == 10'h000 && !shift_busy_q)
    else $error("byte count not cleared by control write");

  AST_WORD_FOUR_CYCLES: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_dat && !wr_ctl) ##1 (!wr_en [*4]) |-> shifting && step_q == 2'h3 ##1 (!shifting && !shift_busy_q))
    else $error("word not finished in four cycles");

  AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_dat && !wr_ctl) ##1 (!wr_en [*3]) |-> shift_busy_q && step_q == 2'h2)
    else $error("word engine left early");

  AST_STOP_AT_LENGTH: assert property (@(posedge clk) disable iff (!reset_n)
    (count_q > {1'b0, len_q} && !wr_ctl) |=> $stable(crc_q) && $stable(count_q))
    else $error("crc moved after packet end");

  AST_COUNT_BOUND: assert property (@(posedge clk) disable iff (!reset_n)
    count_q <= {1'b0, len_q} + 10'h001)
    else $error("byte count beyond length plus one");

  AST_RESET_VALUE: assert property (@(posedge clk)
    !reset_n |=> crc_q == `CRC_SEED && rdata_q == 32'h0000_0000)
    else $error("result not 0xffff after reset");

  AST_RESULT_READ: assert property (@(posedge clk) disable iff (!reset_n)
    rd_res |=> rdata_q == {16'h0000, $past(crc_q)})
    else $error("result read mismatch");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (!reset_n)
    !rd_en |=> rdata_q == 32'h0000_0000)
    else $error("read data outside its cycle");

  AST_MSB_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && step_q == 2'h0 && order_q == MSB_FIRST |-> cur_byte == word_q[31:24])
    else $error("msb first order wrong");

  AST_LSB_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && step_q == 2'h1 && order_q == LSB_FIRST |-> cur_byte == word_q[15:8])
    else $error("lsb first order wrong");

  AST_ZERO_BYTE_FROM_SEED: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && in_packet && !wr_ctl && crc_q == 16'hffff && cur_byte == 8'h00 |=> crc_q == 16'he1f0)
    else $error("byte step does not match polynomial");

  AST_MSB_LAST: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && step_q == 2'h3 && order_q == MSB_FIRST |-> cur_byte == word_q[7:0])
    else $error("msb first last byte wrong");

  AST_LSB_LAST: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && step_q == 2'h3 && order_q == LSB_FIRST |-> cur_byte == word_q[31:24])
    else $error("lsb first last byte wrong");

  AST_CONTROL_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctl |=> order_q == byte_order_type'($past(wdata[`CRC_MODE_BIT]))
      && len_q == $past(wdata[`CRC_LEN_MSB:`CRC_LEN_LSB]))
    else $error("control fields not captured");

  AST_CONTROL_READ: assert property (@(posedge clk) disable iff (!reset_n)
    rd_ctl |=> rdata_q == {15'h0, $past(order_q), 7'h00, $past(len_q)})
    else $error("control read mismatch");

  AST_RESULT_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && hit(addr, `CRC_OFS_RESULT) && !shifting |=> $stable(crc_q) && $stable(count_q))
    else $error("write to result changed state");

  AST_IDLE_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
    !shifting && !wr_ctl |=> $stable(crc_q))
    else $error("crc moved while engine idle");

  AST_BUSY_TRACKS_ENGINE: assert property (@(posedge clk) disable iff (!reset_n)
    shift_busy_q == shifting)
    else $error("busy flag out of step with engine");

  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    shifting && in_packet && !wr_ctl |=> count_q == $past(count_q) + 10'h001)
    else $error("byte count did not advance");

  // ==========================================================
  // coverage

  COV_FULL_PACKET: cover property (@(posedge clk) disable iff (!reset_n)
    count_q == {1'b0, len_q} + 10'h001);

  COV_ZERO_RESIDUE: cover property (@(posedge clk) disable iff (!reset_n)
    count_q == {1'b0, len_q} + 10'h001 && crc_q == 16'h0000);

  COV_LSB_WORD: cover property (@(posedge clk) disable iff (!reset_n)
    shifting && order_q == LSB_FIRST && step_q == 2'h3);

  COV_RESTART_MID_WORD: cover property (@(posedge clk) disable iff (!reset_n)
    shifting && wr_ctl);

  COV_MAX_PACKET: cover property (@(posedge clk) disable iff (!reset_n)
    len_q == 9'h1ff && count_q == 10'h200);

endmodule

`default_nettype wire

// ==== test/cpu_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [3:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [31:0] rdata_q
);
  initial begin
    addr = 4'hf;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // ==========================================================
  // bus cycles
  // released data is inverted so a stale word never looks fresh
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata_q;
  endtask

  // whole word, then the engine gets its four cycles
  task automatic put_word(input logic [31:0] d);
    wr(4'h4, d);
    repeat (3) @(posedge clk);
  endtask

  task automatic ctl(input logic order, input logic [8:0] len_m1);
    wr(4'h0, {15'h0, order, 7'h0, len_m1});
  endtask
endmodule

`default_nettype wire

// ==== test/test_crc16_packet_generator.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_crc16_packet_generator;
  logic        clk;
  logic        reset_n;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata_q;
  logic [31:0] got;
  logic        busy;
  int          err_count;
  int          checked;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  crc16_packet_generator u_crc16_packet_generator (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .shift_busy_q(busy)
  );

  cpu_bus_model u_cpu_bus_model (
    .clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q)
  );

  // ==========================================================
  // reference and compare
  function automatic logic [15:0] ref_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
    end
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
    u_cpu_bus_model.rd(a, got);
    check(got, exp);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_check(4'h0, 32'h0);
    rd_check(4'h4, 32'h0);
    rd_check(4'h8, 32'h0000_ffff);
    rd_check(4'hc, 32'h0);
    u_cpu_bus_model.wr(4'h8, 32'h1234_5678);
    rd_check(4'h8, 32'h0000_ffff);
    $display("test reset done");
  endtask

  task automatic t_example;
    u_cpu_bus_model.ctl(1'b0, 9'h3);
    rd_check(4'h8, 32'h0000_ffff);
    u_cpu_bus_model.put_word(32'h2dcf_4633);
    rd_check(4'h8, 32'h0000_2194);
    u_cpu_bus_model.ctl(1'b0, 9'h5);
    u_cpu_bus_model.put_word(32'h2dcf_4633);
    u_cpu_bus_model.put_word(32'h2194_0000);
    rd_check(4'h8, 32'h0);
    rd_check(4'h4, 32'h2194_0000);
    $display("test example done");
  endtask

  // busy span of one word, and a control write that cuts a word short
  task automatic t_busy;
    u_cpu_bus_model.ctl(1'b0, 9'h3);
    u_cpu_bus_model.wr(4'h4, 32'h2dcf_4633);
    @(posedge clk);
    check({31'h0, busy}, 32'h1);
    u_cpu_bus_model.ctl(1'b0, 9'h3);
    rd_check(4'h8, 32'h0000_ffff);
    check({31'h0, busy}, 32'h0);
    u_cpu_bus_model.wr(4'h4, 32'h2dcf_4633);
    repeat (4) @(posedge clk);
    check({31'h0, busy}, 32'h1);
    @(posedge clk);
    check({31'h0, busy}, 32'h0);
    rd_check(4'h8, 32'h0000_2194);
    $display("test busy done");
  endtask

  // reset in the middle of a word brings every register back
  task automatic t_mid_reset;
    u_cpu_bus_model.ctl(1'b1, 9'h5);
    u_cpu_bus_model.wr(4'h4, 32'h1234_5678);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({31'h0, busy}, 32'h0);
    rd_check(4'h0, 32'h0);
    rd_check(4'h4, 32'h0);
    rd_check(4'h8, 32'h0000_ffff);
    $display("test mid reset done");
  endtask

  task automatic t_order;
    u_cpu_bus_model.ctl(1'b1, 9'h3);
    rd_check(4'h0, 32'h0001_0003);
    u_cpu_bus_model.put_word(32'h3346_cf2d);
    rd_check(4'h8, 32'h0000_2194);
    $display("test order done");
  endtask

  task automatic t_stop;
    u_cpu_bus_model.ctl(1'b0, 9'h1);
    u_cpu_bus_model.put_word(32'h2dcf_4633);
    rd_check(4'h8, 32'h0000_4516);
    u_cpu_bus_model.put_word(32'hffff_ffff);
    rd_check(4'h8, 32'h0000_4516);
    $display("test stop done");
  endtask

  // a half-done packet is thrown away and the byte count starts over
  task automatic t_restart;
    u_cpu_bus_model.ctl(1'b0, 9'h5);
    u_cpu_bus_model.put_word(32'h1234_5678);
    u_cpu_bus_model.ctl(1'b1, 9'h5);
    u_cpu_bus_model.put_word(32'h3346_cf2d);
    u_cpu_bus_model.put_word(32'h0000_9421);
    rd_check(4'h8, 32'h0);
    $display("test restart done");
  endtask

  task automatic t_max;
    logic [15:0] exp;
    logic [31:0] d;
    int          n;
    exp = 16'hffff;
    n = 0;
    u_cpu_bus_model.ctl(1'b0, 9'h1ff);
    for (int w = 0; w < 129; w++) begin
      d = w * 32'h0103_0507 + 32'h5a;
      u_cpu_bus_model.put_word(d);
      for (int k = 3; k >= 0; k--) begin
        if (n < 512) begin
          exp = ref_step(exp, d[8*k +: 8]);
        end
        n++;
      end
    end
    rd_check(4'h8, {16'h0, exp});
    $display("test max length done");
  endtask

  // ==========================================================
  // run control
  task automatic complete_run;
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_example();
    t_busy();
    t_order();
    t_stop();
    t_restart();
    t_mid_reset();
    t_max();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
